// ---- rtl/motor_cmd_pkg.sv ----
// constants for the motor power and service command interpreter
// assumes a host that writes a command word plus numbered parameters over a plain register port
package motor_cmd_pkg;
   // register offsets (word addresses on the plain port)
   localparam logic [3:0] REG_CMD      = 4'h0;
   localparam logic [3:0] REG_PARM0    = 4'h1;
   localparam logic [3:0] REG_PARM1    = 4'h2;
   localparam logic [3:0] REG_RESULT   = 4'h3;
   localparam logic [3:0] REG_HOST_CTL = 4'h4;
   localparam logic [3:0] REG_STATUS   = 4'h5;
   localparam logic [3:0] REG_CONFIG   = 4'h6;
   localparam logic [3:0] REG_MODES    = 4'h7;
   // command codes
   localparam logic [15:0] CMD_MODE_B      = 16'h0201;
   localparam logic [15:0] CMD_HC_A        = 16'h0A00;
   localparam logic [15:0] CMD_HC_B        = 16'h0A01;
   localparam logic [15:0] CMD_SERVICE     = 16'h8001;
   localparam logic [15:0] CMD_FLASH_PROG  = 16'h8002;
   localparam logic [15:0] CMD_FLASH_READ  = 16'h8003;
   localparam logic [15:0] CMD_FLASH_ERASE = 16'h8004;
   localparam logic [15:0] CMD_FLASH_UNLK  = 16'h8005;
   localparam logic [15:0] CMD_GP0_A       = 16'h1000;
   localparam logic [15:0] CMD_GP0_B       = 16'h1001;
   localparam logic [15:0] CMD_GP1_A       = 16'h2000;
   localparam logic [15:0] CMD_GP1_B       = 16'h2001;
   localparam logic [15:0] CMD_GP2_A       = 16'h3000;
   localparam logic [15:0] CMD_GP2_B       = 16'h3001;
   // drive modes, one-hot
   localparam logic [15:0] step_div1           = 16'h0001;
   localparam logic [15:0] step_div2           = 16'h0002;
   localparam logic [15:0] step_div4           = 16'h0004;
   localparam logic [15:0] step_div8           = 16'h0008;
   localparam logic [15:0] step_div16          = 16'h0010;
   localparam logic [15:0] torque_comp_step16  = 16'h0020;
   localparam logic [15:0] single_phase_excite = 16'h0040;
   // result codes
   localparam logic [15:0] RES_OK                 = 16'h0000;
   localparam logic [15:0] invalid_request_result = 16'h0001;
   localparam logic [15:0] RES_NOT_UNLOCKED       = 16'h0002;
   localparam logic [15:0] RES_BAD_PARM           = 16'h0003;
   localparam logic [15:0] RES_BUSY               = 16'hFFFF;
   // field positions
   localparam int HOST_CTL_BRAKE_BIT = 2;
   localparam int CFG_FOUR_PHASE_BIT = 0;
   localparam int STS_UNLOCK_BIT     = 0;
   localparam int STS_BRAKE_BIT      = 1;
   localparam int STS_BUSY_BIT       = 2;
   // hold factor range and flash shape
   localparam logic [15:0] HC_MAX_FACTOR = 16'h0007;
   localparam int FLASH_AW    = 12;
   localparam int FLASH_DEPTH = 4096;
   localparam logic [7:0] FLASH_ERASED = 8'hFF;
   // unlock signature: arbitrary value
   localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA5C3;
   localparam logic [15:0] MODE_B_RESET = 16'h0001;
   typedef enum logic [1:0] {IDLE, EXEC, ERASE} cmd_state_t;
endpackage

// ---- rtl/flash_array.sv ----
// on-board byte flash model: single port, whole-array erase walks one byte per cycle
// assumes the caller only writes or erases while unlocked
module flash_array (
   // clock and reset
   input  wire logic                              mclk,
   input  wire logic                              sys_rst,
   // byte port
   input  wire logic                              wr_en,
   input  wire logic [motor_cmd_pkg::FLASH_AW-1:0] addr,
   input  wire logic [7:0]                        wdata,
   output logic      [7:0]                        rdata,
   // erase
   input  wire logic                              erase_start,
   output logic                                   erase_busy
);
   logic [7:0]                        mem [motor_cmd_pkg::FLASH_DEPTH];
   logic [motor_cmd_pkg::FLASH_AW-1:0] ecnt_q;
   logic [motor_cmd_pkg::FLASH_AW-1:0] ecnt_d;
   logic                              ebusy_q;
   logic                              last_w;

   assign last_w     = (ecnt_q == {motor_cmd_pkg::FLASH_AW{1'b1}});
   assign ecnt_d     = ebusy_q ? ecnt_q + 1'b1 : '0;
   assign erase_busy = ebusy_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ebusy_q <= 1'b0;
         ecnt_q  <= '0;
      end else begin
         ecnt_q  <= ecnt_d;
         ebusy_q <= erase_start | (ebusy_q & ~last_w);
      end
   end

   always_ff @(posedge mclk) begin
      if (ebusy_q) begin
         mem[ecnt_q] <= motor_cmd_pkg::FLASH_ERASED;
      end else if (wr_en) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ---- rtl/motor_cmd_core.sv ----
// command interpreter for drive mode B, hold current and flash service commands, plus brake
// assumes a host writing parameters first and the command word last over a plain register port
//
// Contract
// - code 0201 sets motor B drive mode, same encoding as motor A
// - code 0A00 stores motor A hold factor, applied once positioned
// - hold factor 0..7; hold current is Imax over factor plus one
// - code 0A01 sets motor B hold factor like motor A
// - code 8002 programs byte parm1 at flash offset parm0
// - byte programming only after unlock accepted
// - code 8003 returns flash byte at offset parm0 in parm1
// - code 8004 erases whole flash only when unlocked
// - code 8005 unlocks flash only for valid signature in parm0
// - general output codes answer invalid request result
// - no command code reaches the emergency brake
// - host control bit 2 written one raises mailbox interrupt
// - mailbox interrupt aborts all profiles and shorts windings
// - drive modes one-hot; last two only in two-phase mode
// - four-phase configuration refuses motor B power-stage commands
module motor_cmd_core (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // motor status from the motion engine
   input  wire logic        positioned_a,
   input  wire logic        positioned_b,
   // power-stage outputs
   output logic      [15:0] drive_mode_b,
   output logic      [2:0]  hold_current_factor_a,
   output logic      [2:0]  hold_current_factor_b,
   output logic      [3:0]  current_divisor_a,
   output logic      [3:0]  current_divisor_b,
   output logic             hold_reduce_a,
   output logic             hold_reduce_b,
   // brake
   output logic             abort_profiles,
   output logic             brake_windings,
   input  wire logic        brake_release
);
   // ==========================================================
   // functions
   // ==========================================================
   function automatic logic is_one_hot_mode(input logic [15:0] m, input logic four_ph);
      logic ok;
      ok = 1'b0;
      case (m)
         motor_cmd_pkg::step_div1, motor_cmd_pkg::step_div2, motor_cmd_pkg::step_div4,
         motor_cmd_pkg::step_div8, motor_cmd_pkg::step_div16: ok = 1'b1;
         motor_cmd_pkg::torque_comp_step16, motor_cmd_pkg::single_phase_excite: ok = ~four_ph;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic [3:0] divisor(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction

   // ==========================================================
   // registers
   // ==========================================================
   motor_cmd_pkg::cmd_state_t state_q;
   motor_cmd_pkg::cmd_state_t state_d;
   logic [15:0] cmd_q;
   logic [15:0] parm0_q;
   logic [15:0] parm1_q;
   logic [15:0] result_q;
   logic [15:0] result_d;
   logic [15:0] mode_b_q;
   logic [15:0] mode_b_d;
   logic [2:0]  hc_a_q;
   logic [2:0]  hc_a_d;
   logic [2:0]  hc_b_q;
   logic [2:0]  hc_b_d;
   logic        four_phase_q;
   logic        unlock_q;
   logic        unlock_d;
   logic        brake_q;
   logic        parm1_load;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // flash wires
   logic [7:0]  fl_rdata;
   logic        fl_wr;
   logic        fl_erase;
   logic        fl_busy;

   // ==========================================================
   // decode
   // ==========================================================
   wire wr_cmd    = reg_wr & (reg_addr == motor_cmd_pkg::REG_CMD);
   wire wr_parm0  = reg_wr & (reg_addr == motor_cmd_pkg::REG_PARM0);
   wire wr_parm1  = reg_wr & (reg_addr == motor_cmd_pkg::REG_PARM1);
   wire wr_ctl    = reg_wr & (reg_addr == motor_cmd_pkg::REG_HOST_CTL);
   wire wr_cfg    = reg_wr & (reg_addr == motor_cmd_pkg::REG_CONFIG);
   wire mailbox   = wr_ctl & reg_wdata[motor_cmd_pkg::HOST_CTL_BRAKE_BIT];
   wire exec      = (state_q == motor_cmd_pkg::EXEC);
   wire c_mode_b  = (cmd_q == motor_cmd_pkg::CMD_MODE_B);
   wire c_hc_a    = (cmd_q == motor_cmd_pkg::CMD_HC_A);
   wire c_hc_b    = (cmd_q == motor_cmd_pkg::CMD_HC_B);
   wire c_prog    = (cmd_q == motor_cmd_pkg::CMD_FLASH_PROG);
   wire c_read    = (cmd_q == motor_cmd_pkg::CMD_FLASH_READ);
   wire c_erase   = (cmd_q == motor_cmd_pkg::CMD_FLASH_ERASE);
   wire c_unlk    = (cmd_q == motor_cmd_pkg::CMD_FLASH_UNLK);
   wire c_service = (cmd_q == motor_cmd_pkg::CMD_SERVICE);
   wire hc_ok     = (parm0_q <= motor_cmd_pkg::HC_MAX_FACTOR);
   wire mode_ok   = is_one_hot_mode(parm0_q, four_phase_q);
   wire sig_ok    = (parm0_q == motor_cmd_pkg::UNLOCK_SIGNATURE);

   assign fl_wr    = exec & c_prog & unlock_q;
   assign fl_erase = exec & c_erase & unlock_q;

   // ==========================================================
   // command sequencer
   // ==========================================================
   always_comb begin
      state_d    = state_q;
      result_d   = result_q;
      mode_b_d   = mode_b_q;
      hc_a_d     = hc_a_q;
      hc_b_d     = hc_b_q;
      unlock_d   = unlock_q;
      parm1_load = 1'b0;
      case (state_q)
         motor_cmd_pkg::IDLE: begin
            if (wr_cmd) begin
               state_d  = motor_cmd_pkg::EXEC;
               result_d = motor_cmd_pkg::RES_BUSY;
            end
         end
         motor_cmd_pkg::EXEC: begin
            state_d  = motor_cmd_pkg::IDLE;
            result_d = motor_cmd_pkg::RES_OK;
            if (c_mode_b) begin
               if (four_phase_q) begin
                  result_d = motor_cmd_pkg::invalid_request_result;
               end else if (mode_ok) begin
                  mode_b_d = parm0_q;
               end else begin
                  result_d = motor_cmd_pkg::RES_BAD_PARM;
               end
            end else if (c_hc_a) begin
               if (hc_ok) begin
                  hc_a_d = parm0_q[2:0];
               end else begin
                  result_d = motor_cmd_pkg::RES_BAD_PARM;
               end
            end else if (c_hc_b) begin
               if (four_phase_q) begin
                  result_d = motor_cmd_pkg::invalid_request_result;
               end else if (hc_ok) begin
                  hc_b_d = parm0_q[2:0];
               end else begin
                  result_d = motor_cmd_pkg::RES_BAD_PARM;
               end
            end else if (c_prog) begin
               if (!unlock_q) begin
                  result_d = motor_cmd_pkg::RES_NOT_UNLOCKED;
               end
            end else if (c_read) begin
               state_d  = motor_cmd_pkg::ERASE;
               result_d = motor_cmd_pkg::RES_BUSY;
            end else if (c_erase) begin
               if (unlock_q) begin
                  state_d  = motor_cmd_pkg::ERASE;
                  result_d = motor_cmd_pkg::RES_BUSY;
               end else begin
                  result_d = motor_cmd_pkg::RES_NOT_UNLOCKED;
               end
            end else if (c_unlk) begin
               unlock_d = sig_ok;
               if (!sig_ok) begin
                  result_d = motor_cmd_pkg::invalid_request_result;
               end
            end else if (c_service) begin
               result_d = motor_cmd_pkg::RES_OK;
            end else begin
               result_d = motor_cmd_pkg::invalid_request_result;
            end
         end
         motor_cmd_pkg::ERASE: begin
            if (c_read) begin
               parm1_load = 1'b1;
               state_d    = motor_cmd_pkg::IDLE;
               result_d   = motor_cmd_pkg::RES_OK;
            end else if (!fl_busy) begin
               state_d  = motor_cmd_pkg::IDLE;
               result_d = motor_cmd_pkg::RES_OK;
            end
         end
         default: state_d = motor_cmd_pkg::IDLE;
      endcase
      if (mailbox) begin
         state_d  = motor_cmd_pkg::IDLE;
         result_d = motor_cmd_pkg::RES_OK;
      end
   end

   // ==========================================================
   // state and registers
   // ==========================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q  <= motor_cmd_pkg::IDLE;
         result_q <= motor_cmd_pkg::RES_OK;
         mode_b_q <= motor_cmd_pkg::MODE_B_RESET;
         hc_a_q   <= '0;
         hc_b_q   <= '0;
         unlock_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         result_q <= result_d;
         mode_b_q <= mode_b_d;
         hc_a_q   <= hc_a_d;
         hc_b_q   <= hc_b_d;
         unlock_q <= unlock_d;
      end
   end

   // host-written command and parameters; ignored while a command runs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q        <= '0;
         parm0_q      <= '0;
         parm1_q      <= '0;
         four_phase_q <= 1'b0;
      end else begin
         if (wr_cmd && state_q == motor_cmd_pkg::IDLE) cmd_q <= reg_wdata;
         if (wr_parm0 && state_q == motor_cmd_pkg::IDLE) parm0_q <= reg_wdata;
         if (parm1_load) begin
            parm1_q <= {8'h00, fl_rdata};
         end else if (wr_parm1 && state_q == motor_cmd_pkg::IDLE) begin
            parm1_q <= reg_wdata;
         end
         if (wr_cfg) four_phase_q <= reg_wdata[motor_cmd_pkg::CFG_FOUR_PHASE_BIT];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         brake_q <= 1'b0;
      end else begin
         brake_q <= mailbox | (brake_q & ~brake_release);
      end
   end

   // ==========================================================
   // read port
   // ==========================================================
   wire [15:0] status_w = {13'h0000, (state_q != motor_cmd_pkg::IDLE), brake_q, unlock_q};
   always_comb begin
      case (reg_addr)
         motor_cmd_pkg::REG_CMD:      rdata_d = cmd_q;
         motor_cmd_pkg::REG_PARM0:    rdata_d = parm0_q;
         motor_cmd_pkg::REG_PARM1:    rdata_d = parm1_q;
         motor_cmd_pkg::REG_RESULT:   rdata_d = result_q;
         motor_cmd_pkg::REG_STATUS:   rdata_d = status_w;
         motor_cmd_pkg::REG_CONFIG:   rdata_d = {15'h0000, four_phase_q};
         motor_cmd_pkg::REG_MODES:    rdata_d = {10'h000, hc_b_q, hc_a_q};
         default:                     rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd ? rdata_d : 16'h0000;
      end
   end
   assign reg_rdata = rdata_q;

   // ==========================================================
   // outputs
   // ==========================================================
   assign drive_mode_b          = mode_b_q;
   assign hold_current_factor_a = hc_a_q;
   assign hold_current_factor_b = hc_b_q;
   assign current_divisor_a     = (positioned_a && !brake_q) ? divisor(hc_a_q) : 4'h1;
   assign current_divisor_b     = (positioned_b && !brake_q) ? divisor(hc_b_q) : 4'h1;
   assign hold_reduce_a         = positioned_a & (hc_a_q != 3'h0);
   assign hold_reduce_b         = positioned_b & (hc_b_q != 3'h0);
   assign abort_profiles        = brake_q;
   assign brake_windings        = brake_q;

   // ==========================================================
   // flash
   // ==========================================================
   flash_array u_flash (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .wr_en       (fl_wr),
      .addr        (parm0_q[motor_cmd_pkg::FLASH_AW-1:0]),
      .wdata       (parm1_q[7:0]),
      .rdata       (fl_rdata),
      .erase_start (fl_erase),
      .erase_busy  (fl_busy)
   );
endmodule

// ---- dv/motor_cmd_core_asserts.sv ----
// concurrent checks on the ports of the motor command interpreter
// assumes one clock domain and the port names of motor_cmd_core
module motor_cmd_core_chk (
   // clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // motor side
   input wire logic        positioned_a,
   input wire logic        positioned_b,
   input wire logic [15:0] drive_mode_b,
   input wire logic [2:0]  hold_current_factor_a,
   input wire logic [2:0]  hold_current_factor_b,
   input wire logic [3:0]  current_divisor_a,
   input wire logic [3:0]  current_divisor_b,
   input wire logic        hold_reduce_a,
   input wire logic        abort_profiles,
   input wire logic        brake_windings,
   input wire logic        brake_release
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // mailbox write decode
   logic mbx_q;
   wire  mbx_wr = reg_wr && reg_addr == motor_cmd_pkg::REG_HOST_CTL && reg_wdata[motor_cmd_pkg::HOST_CTL_BRAKE_BIT];
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) mbx_q <= 1'b0;
      else mbx_q <= mbx_wr;
   end
   // ==========================================
   // properties
   property p_mailbox; mbx_wr |=> abort_profiles && brake_windings; endproperty
   a_mailbox: assert property (p_mailbox) else $error("brake not raised after mailbox");
   property p_brake_pair; abort_profiles == brake_windings; endproperty
   a_brake_pair: assert property (p_brake_pair) else $error("abort and brake differ");
   property p_rise_cause; $rose(abort_profiles) |-> mbx_q; endproperty
   a_rise_cause: assert property (p_rise_cause) else $error("brake raised without mailbox");
   property p_release; abort_profiles && brake_release && !mbx_wr |=> !abort_profiles; endproperty
   a_release: assert property (p_release) else $error("brake not released");
   property p_div_a;
      current_divisor_a == ((positioned_a && !brake_windings) ? {1'b0, hold_current_factor_a} + 4'h1 : 4'h1);
   endproperty
   a_div_a: assert property (p_div_a) else $error("divisor a wrong");
   property p_div_b;
      current_divisor_b == ((positioned_b && !brake_windings) ? {1'b0, hold_current_factor_b} + 4'h1 : 4'h1);
   endproperty
   a_div_b: assert property (p_div_b) else $error("divisor b wrong");
   property p_reduce_a; hold_reduce_a == (positioned_a && hold_current_factor_a != 3'h0); endproperty
   a_reduce_a: assert property (p_reduce_a) else $error("hold reduce a wrong");
   property p_onehot; $onehot(drive_mode_b); endproperty
   a_onehot: assert property (p_onehot) else $error("mode b not one-hot");
   property p_rdata_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule

bind motor_cmd_core motor_cmd_core_chk chk_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .positioned_a(positioned_a), .positioned_b(positioned_b), .drive_mode_b(drive_mode_b),
   .hold_current_factor_a(hold_current_factor_a), .hold_current_factor_b(hold_current_factor_b),
   .current_divisor_a(current_divisor_a), .current_divisor_b(current_divisor_b),
   .hold_reduce_a(hold_reduce_a), .abort_profiles(abort_profiles), .brake_windings(brake_windings),
   .brake_release(brake_release));

// ---- dv/host_bus.sv ----
// host model: plain register port master issuing coded commands
// assumes read data stands only in the cycle after the read strobe
module host_bus (
   // clock
   input  wire logic        mclk,
   // register port
   output logic      [3:0]  reg_addr,
   output logic      [15:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // parameters first, command word last, then poll while busy
   task automatic cmd(input logic [15:0] c, p0, p1, output logic [15:0] res, r1);
      int n;
      wr(motor_cmd_pkg::REG_PARM0, p0);
      wr(motor_cmd_pkg::REG_PARM1, p1);
      wr(motor_cmd_pkg::REG_CMD, c);
      n = 0;
      res = motor_cmd_pkg::RES_BUSY;
      while (res === motor_cmd_pkg::RES_BUSY && n < 6000) begin
         rd(motor_cmd_pkg::REG_RESULT, res);
         n++;
      end
      rd(motor_cmd_pkg::REG_PARM1, r1);
   endtask
endmodule

// ---- dv/motor_power_service_commands_test.sv ----
// self-checking bench for the motor command interpreter
// assumes host_bus as register master and the bound port checker
module motor_power_service_commands_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, sys_rst, positioned_a, positioned_b, brake_release;
   logic [3:0]  reg_addr, current_divisor_a, current_divisor_b;
   logic [15:0] reg_wdata, reg_rdata, drive_mode_b;
   logic        reg_wr, reg_rd, hold_reduce_a, hold_reduce_b, abort_profiles, brake_windings;
   logic [2:0]  hold_current_factor_a, hold_current_factor_b;
   int          fail_count, cmp_count;
   localparam logic [15:0] gp_codes [6] = '{16'h1000, 16'h1001, 16'h2000, 16'h2001, 16'h3000, 16'h3001};
   localparam logic [15:0] modes [7] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040};
   host_bus host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   motor_cmd_core dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .positioned_a(positioned_a),
      .positioned_b(positioned_b), .drive_mode_b(drive_mode_b), .hold_current_factor_a(hold_current_factor_a),
      .hold_current_factor_b(hold_current_factor_b), .current_divisor_a(current_divisor_a),
      .current_divisor_b(current_divisor_b), .hold_reduce_a(hold_reduce_a), .hold_reduce_b(hold_reduce_b),
      .abort_profiles(abort_profiles), .brake_windings(brake_windings), .brake_release(brake_release));
   // ==========================================
   // checking helpers
   function automatic logic [15:0] divisor(input logic [2:0] f, input logic pos);
      return pos ? 16'(f) + 16'h0001 : 16'h0001;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic run(input logic [15:0] c, p0, p1, exp, output logic [15:0] r1);
      logic [15:0] res;
      host_u.cmd(c, p0, p1, res, r1);
      if (res === motor_cmd_pkg::RES_BUSY) begin
         fail_count++;
         print_verdict();
      end
      chk(res, exp);
   endtask
   // ==========================================
   // stimulus
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      logic [15:0] r1, v;
      logic [11:0] off;
      logic [7:0]  b;
      logic [2:0]  ha, hb;
      int          f, g;
      sys_rst = 1'b1;
      positioned_a = 1'b0;
      positioned_b = 1'b0;
      brake_release = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      ha = 3'h0;
      hb = 3'h0;
      void'($urandom(98));
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      chk(drive_mode_b, motor_cmd_pkg::step_div1);
      foreach (gp_codes[i]) run(gp_codes[i], 16'h0001, 16'h0000, motor_cmd_pkg::invalid_request_result, r1);
      foreach (modes[i]) begin
         run(motor_cmd_pkg::CMD_MODE_B, modes[i], 16'h0000, motor_cmd_pkg::RES_OK, r1);
         chk(drive_mode_b, modes[i]);
      end
      run(motor_cmd_pkg::CMD_MODE_B, 16'h0003, 16'h0000, motor_cmd_pkg::RES_BAD_PARM, r1);
      chk(drive_mode_b, modes[6]);
      for (int i = 0; i < 12; i++) begin
         f = (i == 0) ? 0 : (i == 1) ? 7 : (i == 2) ? 8 : int'($urandom_range(8, 0));
         g = int'($urandom_range(8, 0));
         @(posedge mclk);
         positioned_a <= 1'($urandom);
         positioned_b <= 1'($urandom);
         run(motor_cmd_pkg::CMD_HC_A, 16'(f), 16'h0000, f > 7 ? 16'h0003 : 16'h0000, r1);
         if (f <= 7) ha = 3'(f);
         run(motor_cmd_pkg::CMD_HC_B, 16'(g), 16'h0000, g > 7 ? 16'h0003 : 16'h0000, r1);
         if (g <= 7) hb = 3'(g);
         chk(16'(hold_current_factor_a), 16'(ha));
         chk(16'(current_divisor_a), divisor(ha, positioned_a));
         chk(16'(hold_reduce_a), 16'(positioned_a && ha != 3'h0));
         chk(16'(current_divisor_b), divisor(hb, positioned_b));
         chk(16'(hold_reduce_b), 16'(positioned_b && hb != 3'h0));
      end
      host_u.wr(motor_cmd_pkg::REG_CONFIG, 16'h0001);
      run(motor_cmd_pkg::CMD_HC_B, 16'h0001, 16'h0000, motor_cmd_pkg::invalid_request_result, r1);
      run(motor_cmd_pkg::CMD_MODE_B, 16'h0002, 16'h0000, motor_cmd_pkg::invalid_request_result, r1);
      chk(16'(hold_current_factor_b), 16'(hb));
      host_u.wr(motor_cmd_pkg::REG_CONFIG, 16'h0000);
      off = 12'($urandom);
      run(motor_cmd_pkg::CMD_FLASH_UNLK, motor_cmd_pkg::UNLOCK_SIGNATURE, 16'h0000, 16'h0000, r1);
      run(motor_cmd_pkg::CMD_FLASH_ERASE, 16'h0000, 16'h0000, motor_cmd_pkg::RES_OK, r1);
      run(motor_cmd_pkg::CMD_FLASH_READ, 16'(off), 16'h0000, motor_cmd_pkg::RES_OK, r1);
      chk(16'(r1[7:0]), 16'(motor_cmd_pkg::FLASH_ERASED));
      for (int i = 0; i < 4; i++) begin
         off = 12'($urandom);
         b = 8'($urandom);
         run(motor_cmd_pkg::CMD_FLASH_PROG, 16'(off), 16'(b), motor_cmd_pkg::RES_OK, r1);
         run(motor_cmd_pkg::CMD_FLASH_READ, 16'(off), 16'h0000, motor_cmd_pkg::RES_OK, r1);
         chk(16'(r1[7:0]), 16'(b));
      end
      // locked again: a written byte must survive refused program and erase
      run(motor_cmd_pkg::CMD_FLASH_UNLK, ~motor_cmd_pkg::UNLOCK_SIGNATURE, 16'h0000, 16'h0001, r1);
      run(motor_cmd_pkg::CMD_FLASH_READ, 16'(off), 16'h0000, motor_cmd_pkg::RES_OK, v);
      run(motor_cmd_pkg::CMD_FLASH_PROG, 16'(off), 16'(~v[7:0]), motor_cmd_pkg::RES_NOT_UNLOCKED, r1);
      run(motor_cmd_pkg::CMD_FLASH_ERASE, 16'h0000, 16'h0000, motor_cmd_pkg::RES_NOT_UNLOCKED, r1);
      run(motor_cmd_pkg::CMD_FLASH_PROG, 16'(off), 16'(~v[7:0]), motor_cmd_pkg::RES_NOT_UNLOCKED, r1);
      run(motor_cmd_pkg::CMD_FLASH_READ, 16'(off), 16'h0000, motor_cmd_pkg::RES_OK, r1);
      chk(16'(r1[7:0]), 16'(v[7:0]));
      run(motor_cmd_pkg::CMD_FLASH_UNLK, motor_cmd_pkg::UNLOCK_SIGNATURE, 16'h0000, 16'h0000, r1);
      host_u.wr(motor_cmd_pkg::REG_HOST_CTL, 16'hFFFB);
      #1;
      chk(16'(abort_profiles), 16'h0000);
      // mailbox in the first cycle of a long erase
      @(posedge mclk) positioned_a <= 1'b1;
      host_u.wr(motor_cmd_pkg::REG_CMD, motor_cmd_pkg::CMD_FLASH_ERASE);
      host_u.wr(motor_cmd_pkg::REG_HOST_CTL, 16'h0004);
      #1;
      chk(16'(brake_windings), 16'h0001);
      chk(16'(current_divisor_a), 16'h0001);
      host_u.rd(motor_cmd_pkg::REG_RESULT, r1);
      chk(r1, motor_cmd_pkg::RES_OK);
      @(posedge mclk) brake_release <= 1'b1;
      @(posedge mclk) brake_release <= 1'b0;
      #1;
      chk(16'(abort_profiles), 16'h0000);
      print_verdict();
   end
endmodule
